// File: switch_link_operation_control.sv
`timescale 1ns/100ps
`default_nettype none

module switch_link_operation_control #(
	parameter int NPORTS = link_ctl_pkg::NUM_PORTS,
	parameter int LANES  = link_ctl_pkg::UP_LANES
) (
	input  wire logic                                i_core_clk,           // Core clock, 200 MHz.
	input  wire logic                                i_srst,               // Sync reset, active high.
	input  wire logic                                i_fundamental_reset_pin_n, // Fundamental reset pin, low active.
	input  wire logic                                i_register_unlock_bit,// Unlock from switch control reg.
	input  wire logic                                i_max_width_wr,       // Write strobe for max width field.
	input  wire logic [2:0]                          i_max_width_field,    // New max width value.
	input  wire link_ctl_pkg::port_ctl_t [NPORTS-1:0] i_port_ctl,           // Per-port controls.
	input  wire logic [NPORTS-1:0]                   i_train_done,         // Per-port training done.
	input  wire logic [NPORTS-1:0]                   i_rx_detect,          // Per-port receiver detected.
	input  wire logic [2:0]                          i_trained_width,      // Upstream width from training.
	input  wire logic                                i_lanes_reversed,     // Training found reversed lanes.
	input  wire logic [LANES-1:0]                    i_ts_valid,           // TS symbol strobe per lane.
	input  wire logic [LANES*5-1:0]                  i_ts_index,           // TS symbol index per lane.
	input  wire logic [LANES-1:0]                    i_ts_inv,             // Inverted symbol seen per lane.
	input  wire logic [LANES*10-1:0]                 i_rx_data,            // Raw receive data per lane.
	input  wire logic [LANES*10-1:0]                 i_tx_data,            // Transmit data per lane.
	input  wire logic                                i_spl_msg_valid,      // Upstream slot power message.
	input  wire logic [15:0]                         i_spl_payload,        // Message payload bytes 1:0.
	output logic      [LANES*10-1:0]                 o_rx_data,            // Corrected, reordered rx data.
	output logic      [LANES*10-1:0]                 o_tx_data,            // Reordered tx data.
	output logic      [LANES-1:0]                    o_lane_inverted,      // Per-lane polarity state.
	output logic      [2:0]                          o_max_width_field,    // Max width capability.
	output logic      [2:0]                          o_negotiated_width_field, // Negotiated width.
	output logic      [LANES-1:0]                    o_up_lane_pd,         // Upstream lane power down.
	output logic      [NPORTS-1:0]                   o_port_serdes_pd,     // Port SerDes power down.
	output link_ctl_pkg::ltssm_state_t [NPORTS-1:0]  o_ltssm_state,        // Per-port LTSSM state.
	output logic      [NPORTS-1:0]                   o_link_up,            // Link operational.
	output logic      [NPORTS-1:0]                   o_flush_queue,        // Discard queued packets pulse.
	output logic      [NPORTS-1:0]                   o_ur_to_port,         // Treat traffic to port as UR.
	output logic      [NPORTS-1:0]                   o_cfg_accept,         // Bridge config accepted.
	output logic      [NPORTS-1:0]                   o_fc_advertise,       // Advertise credits pulse.
	output logic      [NPORTS-1:0]                   o_spl_send,           // Send slot power msg pulse.
	output logic      [NPORTS-1:0]                   o_tlp_dllp_block,     // Block TLP/DLLP traffic.
	output link_ctl_pkg::slot_power_t                o_captured_power      // Captured scale and value.
);
	typedef struct packed {
		logic [2:0]                max_w;
		logic [2:0]                cfg_w;
		logic [2:0]                neg_w;
		logic                      rev;
		logic [NPORTS-1:0]         up_prev;
		logic [NPORTS-1:0]         flush;
		logic [NPORTS-1:0]         fc;
		logic [NPORTS-1:0]         spl;
		link_ctl_pkg::slot_power_t pwr;
		logic [2:0]                rst_sync;
		logic                      rst_hold;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;

	logic [NPORTS-1:0] up_w;
	logic [NPORTS-1:0] down_w;
	logic [NPORTS-1:0] retrain_w;
	logic [LANES*10-1:0] rx_fix;
	logic perst;

	// Lane index after reversal within the configured width.
	function automatic int unsigned lane_map(input int unsigned l, input logic [2:0] w, input logic r);
		int unsigned n;
		n = (w == link_ctl_pkg::WIDTH_X4) ? 4 : (w == link_ctl_pkg::WIDTH_X2) ? 2 : 1;
		if (r && l < n) begin
			return n - 1 - l;
		end
		return l;
	endfunction

	function automatic logic legal_width(input logic [2:0] w);
		return w == link_ctl_pkg::WIDTH_X1 || w == link_ctl_pkg::WIDTH_X2 || w == link_ctl_pkg::WIDTH_X4;
	endfunction

	// Pin reset passes three flops; a new level counts only once the last two agree.
	assign perst = s_q.rst_hold;

	always_comb begin
		s_d = s_q;
		s_d.rst_sync = {s_q.rst_sync[1:0], i_fundamental_reset_pin_n};
		if (s_q.rst_sync[2] == s_q.rst_sync[1]) begin
			s_d.rst_hold = ~s_q.rst_sync[2];
		end
		if (i_register_unlock_bit && i_max_width_wr && legal_width(i_max_width_field)) begin
			s_d.max_w = i_max_width_field;
		end
		if (o_ltssm_state[0] inside {link_ctl_pkg::LS_DETECT, link_ctl_pkg::LS_POLLING}) begin
			s_d.cfg_w = s_q.max_w;
		end
		// Width is taken only as Configuration completes, so Detect and Polling keep the old report.
		if (i_train_done[0] && o_ltssm_state[0] == link_ctl_pkg::LS_CONFIG) begin
			s_d.neg_w = (i_trained_width > s_q.cfg_w || !legal_width(i_trained_width))
				? s_q.cfg_w : i_trained_width;
			s_d.rev   = i_lanes_reversed;
		end
		s_d.up_prev = up_w;
		s_d.flush   = s_q.up_prev & ~up_w;
		s_d.fc      = up_w & ~s_q.up_prev;
		for (int p = 1; p < NPORTS; p++) begin
			s_d.spl[p] = (up_w[p] & ~s_q.up_prev[p]) | (i_port_ctl[p].slot_cap_write & up_w[p]);
		end
		s_d.spl[0] = 1'b0;
		if (i_spl_msg_valid) begin
			s_d.pwr.scale = i_spl_payload[7:0];
			s_d.pwr.value = i_spl_payload[9:8];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_q.max_w    <= link_ctl_pkg::MAX_WIDTH_RST;
			s_q.cfg_w    <= link_ctl_pkg::MAX_WIDTH_RST;
			s_q.neg_w    <= link_ctl_pkg::NEG_WIDTH_RST;
			s_q.rev      <= 1'b0;
			s_q.up_prev  <= '0;
			s_q.flush    <= '0;
			s_q.fc       <= '0;
			s_q.spl      <= '0;
			s_q.pwr      <= {link_ctl_pkg::PWR_SCALE_RST, link_ctl_pkg::PWR_VALUE_RST};
			s_q.rst_sync <= 3'h7;
			s_q.rst_hold <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NPORTS; g++) begin : g_port
			if (g == 0) begin : g_up
				assign retrain_w[g] = i_port_ctl[g].link_retrain_bit & i_register_unlock_bit;
			end else begin : g_dn
				assign retrain_w[g] = i_port_ctl[g].link_retrain_bit;
			end
			port_ltssm u_ltssm (
				.i_core_clk    (i_core_clk),
				.i_srst        (i_srst),
				.i_perst       (perst),
				.i_retrain     (retrain_w[g]),
				.i_full_retrain(i_port_ctl[g].full_retrain_bit),
				.i_ctl         (i_port_ctl[g]),
				.i_train_done  (i_train_done[g]),
				.i_rx_detect   (i_rx_detect[g]),
				.o_state       (o_ltssm_state[g]),
				.o_link_up     (up_w[g]),
				.o_link_down   (down_w[g])
			);
			assign o_tlp_dllp_block[g] = down_w[g] | o_ltssm_state[g] == link_ctl_pkg::LS_L23_RDY
				| o_ltssm_state[g] == link_ctl_pkg::LS_L2;
			assign o_ur_to_port[g]     = ~up_w[g];
			assign o_port_serdes_pd[g] = i_port_ctl[g].port_disable;
		end
		for (g = 0; g < LANES; g++) begin : g_lane
			lane_polarity u_pol (
				.i_core_clk(i_core_clk),
				.i_srst    (i_srst),
				.i_training(down_w[0] | o_ltssm_state[0] == link_ctl_pkg::LS_RECOVERY),
				.i_ts_valid(i_ts_valid[g]),
				.i_ts_index(i_ts_index[g*5 +: 5]),
				.i_ts_inv  (i_ts_inv[g]),
				.i_rx_data (i_rx_data[g*10 +: 10]),
				.o_rx_data (rx_fix[g*10 +: 10]),
				.o_inverted(o_lane_inverted[g])
			);
			assign o_up_lane_pd[g] = i_port_ctl[0].port_disable
				| (up_w[0] && g >= int'(s_q.neg_w));
		end
	endgenerate

	always_comb begin
		o_rx_data = '0;
		o_tx_data = '0;
		for (int l = 0; l < LANES; l++) begin
			o_rx_data[l*10 +: 10] = rx_fix[lane_map(l, s_q.cfg_w, s_q.rev)*10 +: 10];
			o_tx_data[l*10 +: 10] = i_tx_data[lane_map(l, s_q.cfg_w, s_q.rev)*10 +: 10];
		end
	end

	assign o_cfg_accept             = '1;
	assign o_max_width_field        = s_q.max_w;
	assign o_negotiated_width_field = s_q.neg_w;
	assign o_flush_queue            = s_q.flush;
	assign o_fc_advertise           = s_q.fc;
	assign o_spl_send               = s_q.spl;
	assign o_link_up                = up_w;
	assign o_captured_power         = s_q.pwr;

	a_width_lock: assert property (@(posedge i_core_clk) disable iff (i_srst)
		!i_register_unlock_bit |=> $stable(o_max_width_field)) else $error("max width changed while locked");
	a_width_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
		up_w[0] && $past(up_w[0]) |-> $stable(o_negotiated_width_field)) else $error("width moved on live link");
	a_spl_capture: assert property (@(posedge i_core_clk) disable iff (i_srst)
		i_spl_msg_valid |=> o_captured_power.value == $past(i_spl_payload[9:8])
		&& o_captured_power.scale == $past(i_spl_payload[7:0])) else $error("slot power not captured");
	a_fc_on_up: assert property (@(posedge i_core_clk) disable iff (i_srst)
		$rose(up_w[1]) |=> o_fc_advertise[1] && o_spl_send[1]) else $error("no credits or power msg at link up");
	a_flush_down: assert property (@(posedge i_core_clk) disable iff (i_srst)
		$fell(up_w[2]) |=> o_flush_queue[2]) else $error("queue not flushed at link down");
	c_x2: cover property (@(posedge i_core_clk) disable iff (i_srst) up_w[0] && s_q.neg_w == link_ctl_pkg::WIDTH_X2);
	c_spl: cover property (@(posedge i_core_clk) disable iff (i_srst) i_spl_msg_valid);

endmodule

`default_nettype wire

// File: link_ctl_pkg.sv
package link_ctl_pkg;

	localparam int NUM_PORTS      = 5;
	localparam int UP_LANES       = 4;
	localparam int SYM_FIRST      = 6;
	localparam int SYM_LAST       = 16;

	localparam logic [2:0] WIDTH_X1 = 3'h1;
	localparam logic [2:0] WIDTH_X2 = 3'h2;
	localparam logic [2:0] WIDTH_X4 = 3'h4;
	localparam logic [2:0] MAX_WIDTH_RST = 3'h4;
	localparam logic [2:0] NEG_WIDTH_RST = 3'h0;
	localparam logic [7:0] PWR_SCALE_RST = 8'h00;
	localparam logic [1:0] PWR_VALUE_RST = 2'h0;

	typedef enum logic [3:0] {
		LS_DETECT   = 4'h0,
		LS_POLLING  = 4'h1,
		LS_CONFIG   = 4'h3,
		LS_L0       = 4'h2,
		LS_L0S      = 4'h6,
		LS_L1       = 4'h7,
		LS_RECOVERY = 4'h5,
		LS_L23_RDY  = 4'h4,
		LS_L2       = 4'hC,
		LS_DISABLED = 4'hD,
		LS_LOOPBACK = 4'hF,
		LS_HOT_RST  = 4'hE
	} ltssm_state_t;

	typedef struct packed {
		logic [7:0] scale;
		logic [1:0] value;
	} slot_power_t;

	typedef struct packed {
		logic       link_retrain_bit;
		logic       full_retrain_bit;
		logic       port_disable;
		logic       d3_hot;
		logic       aspm_l1_req;
		logic       turn_off_acked;
		logic       slot_cap_write;
	} port_ctl_t;

endpackage

// File: lane_polarity.sv
`timescale 1ns/100ps
`default_nettype none

// Receive polarity detector for one lane; decided and held on its own.
module lane_polarity (
	input  wire logic       i_core_clk,  // Core clock.
	input  wire logic       i_srst,      // Sync reset.
	input  wire logic       i_training,  // Link is training.
	input  wire logic       i_ts_valid,  // TS1/TS2 symbol strobe.
	input  wire logic [4:0] i_ts_index,  // Symbol index in ordered set.
	input  wire logic       i_ts_inv,    // Symbol seen as inverted.
	input  wire logic [9:0] i_rx_data,   // Raw receive symbol.
	output logic      [9:0] o_rx_data,   // Corrected receive symbol.
	output logic            o_inverted   // Inversion held.
);
	typedef struct packed {
		logic       inv;
		logic [9:0] data;
	} pol_state_t;

	pol_state_t s_q;
	pol_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (i_training && i_ts_valid && i_ts_index >= 5'(link_ctl_pkg::SYM_FIRST)
			&& i_ts_index <= 5'(link_ctl_pkg::SYM_LAST)) begin
			// Each checked symbol restates the lane's polarity; toggling would flip back on the next inverted symbol.
			s_d.inv = i_ts_inv;
		end
		s_d.data = s_d.inv ? ~i_rx_data : i_rx_data;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rx_data  = s_q.data;
	assign o_inverted = s_q.inv;

	a_pol_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
		!i_training |=> $stable(o_inverted)) else $error("polarity changed outside training");
	a_pol_apply: assert property (@(posedge i_core_clk) disable iff (i_srst)
		##1 (o_rx_data == (o_inverted ? ~$past(i_rx_data) : $past(i_rx_data))))
		else $error("rx data not corrected");
	c_pol_flip: cover property (@(posedge i_core_clk) disable iff (i_srst) $rose(o_inverted));

endmodule

`default_nettype wire

// File: port_ltssm.sv
`timescale 1ns/100ps
`default_nettype none

// Per-port link state tracker with retrain and power state handling.
module port_ltssm (
	input  wire logic                            i_core_clk,    // Core clock.
	input  wire logic                            i_srst,        // Sync reset.
	input  wire logic                            i_perst,       // Synchronised fundamental reset.
	input  wire logic                            i_retrain,     // Qualified retrain request.
	input  wire logic                            i_full_retrain,// Full retrain request.
	input  wire link_ctl_pkg::port_ctl_t          i_ctl,         // Port controls.
	input  wire logic                            i_train_done,  // PHY finished training.
	input  wire logic                            i_rx_detect,   // Receiver detected.
	output link_ctl_pkg::ltssm_state_t           o_state,       // Current state.
	output logic                                 o_link_up,     // Link operational.
	output logic                                 o_link_down    // Link-down pseudo-state.
);
	typedef struct packed {
		link_ctl_pkg::ltssm_state_t st;
	} lt_state_t;

	lt_state_t s_q;
	lt_state_t s_d;

	always_comb begin
		s_d = s_q;
		case (s_q.st)
			link_ctl_pkg::LS_DETECT:   if (i_rx_detect) s_d.st = link_ctl_pkg::LS_POLLING;
			link_ctl_pkg::LS_POLLING:  s_d.st = link_ctl_pkg::LS_CONFIG;
			link_ctl_pkg::LS_CONFIG:   if (i_train_done) s_d.st = link_ctl_pkg::LS_L0;
			link_ctl_pkg::LS_RECOVERY: if (i_train_done) s_d.st = link_ctl_pkg::LS_L0;
			link_ctl_pkg::LS_L0, link_ctl_pkg::LS_L0S: begin
				if (i_ctl.turn_off_acked) begin
					s_d.st = link_ctl_pkg::LS_L23_RDY;
				end else if (i_ctl.aspm_l1_req || i_ctl.d3_hot) begin
					s_d.st = link_ctl_pkg::LS_L1;
				end
			end
			link_ctl_pkg::LS_L1:       if (!i_ctl.d3_hot && !i_ctl.aspm_l1_req) s_d.st = link_ctl_pkg::LS_RECOVERY;
			link_ctl_pkg::LS_L23_RDY:  s_d.st = link_ctl_pkg::LS_L2;
			link_ctl_pkg::LS_L2:       s_d.st = link_ctl_pkg::LS_L2;
			link_ctl_pkg::LS_DISABLED: if (!i_ctl.port_disable) s_d.st = link_ctl_pkg::LS_DETECT;
			default:                   s_d.st = link_ctl_pkg::LS_DETECT;
		endcase
		if (s_q.st != link_ctl_pkg::LS_L2 && s_q.st != link_ctl_pkg::LS_L23_RDY) begin
			if (i_ctl.port_disable) begin
				s_d.st = link_ctl_pkg::LS_DISABLED;
			end else if (i_full_retrain) begin
				s_d.st = link_ctl_pkg::LS_DETECT;
			end else if (i_retrain && s_q.st inside {link_ctl_pkg::LS_L0, link_ctl_pkg::LS_L0S,
					link_ctl_pkg::LS_L1}) begin
				s_d.st = link_ctl_pkg::LS_RECOVERY;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst || i_perst) begin
			s_q.st <= link_ctl_pkg::LS_DETECT;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_state     = s_q.st;
	assign o_link_up   = s_q.st inside {link_ctl_pkg::LS_L0, link_ctl_pkg::LS_L0S,
		link_ctl_pkg::LS_L1, link_ctl_pkg::LS_RECOVERY};
	assign o_link_down = s_q.st inside {link_ctl_pkg::LS_DETECT, link_ctl_pkg::LS_POLLING,
		link_ctl_pkg::LS_CONFIG, link_ctl_pkg::LS_DISABLED, link_ctl_pkg::LS_LOOPBACK,
		link_ctl_pkg::LS_HOT_RST};

	a_l2_sticky: assert property (@(posedge i_core_clk) disable iff (i_srst || i_perst)
		o_state == link_ctl_pkg::LS_L2 |=> o_state == link_ctl_pkg::LS_L2) else $error("left L2 without reset");
	a_full_detect: assert property (@(posedge i_core_clk) disable iff (i_srst || i_perst)
		i_full_retrain && !i_ctl.port_disable && !(o_state inside {link_ctl_pkg::LS_L2, link_ctl_pkg::LS_L23_RDY})
		|=> o_state == link_ctl_pkg::LS_DETECT) else $error("full retrain missed detect");
	a_l23_ack: assert property (@(posedge i_core_clk) disable iff (i_srst || i_perst)
		$changed(o_state) && o_state == link_ctl_pkg::LS_L23_RDY |-> $past(i_ctl.turn_off_acked))
		else $error("L2/L3 ready without ack");
	c_recovery: cover property (@(posedge i_core_clk) disable iff (i_srst) o_state == link_ctl_pkg::LS_RECOVERY);
	c_l2: cover property (@(posedge i_core_clk) disable iff (i_srst) o_state == link_ctl_pkg::LS_L2);

endmodule

`default_nettype wire

// File: link_partner_model.sv
`timescale 1ns/100ps
`default_nettype none

// Far-side link partners: each port detects once enabled, then finishes training after a programmable delay.
module link_partner_model #(
	parameter int NPORTS = 5
) (
	input  wire logic              i_core_clk,      // Core clock.
	input  wire logic [NPORTS-1:0] i_go,            // Partner present and willing to train.
	input  wire logic [2:0]        i_width,         // Lanes the upstream partner can drive.
	input  wire logic [7:0]        i_delay,         // Cycles from detect to training done.
	output logic      [NPORTS-1:0] o_rx_detect,     // Receiver detected.
	output logic      [NPORTS-1:0] o_train_done,    // Training finished.
	output logic      [2:0]        o_trained_width  // Width reached by training.
);
	int cnt [NPORTS];

	initial begin
		o_rx_detect  = '0;
		o_train_done = '0;
		foreach (cnt[p]) cnt[p] = 0;
	end

	assign o_trained_width = i_width;

	always @(posedge i_core_clk) begin
		#1;
		for (int p = 0; p < NPORTS; p++) begin
			o_rx_detect[p]  = i_go[p];
			o_train_done[p] = i_go[p] && (cnt[p] >= int'(i_delay));
			cnt[p]          = i_go[p] ? cnt[p] + 1 : 0;
		end
	end
endmodule

`default_nettype wire

// File: tb_switch_link_operation_control.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin miscompares++; $display("Error %s expected %0h seen %0h", nm, exp, got); end end

module tb_switch_link_operation_control;
	logic                              i_core_clk = 1'b0;
	logic                              srst = 1'b1;
	logic                              pin_n = 1'b1;
	logic                              unlock = 1'b0;
	logic                              mw_wr = 1'b0;
	logic                              spl_v = 1'b0;
	logic                              rev = 1'b0;
	logic [2:0]                        mw = 3'h4;
	logic [2:0]                        pw = 3'h4;
	logic [7:0]                        dly = 8'h02;
	logic [4:0]                        go = 5'h00;
	logic [3:0]                        tsv = 4'h0;
	logic [3:0]                        tsinv = 4'h0;
	logic [19:0]                       tsidx = 20'h00000;
	logic [39:0]                       rxd = 40'h0000000000;
	logic [39:0]                       txd = 40'h0000000000;
	logic [15:0]                       pay = 16'h0000;
	link_ctl_pkg::port_ctl_t [4:0]     ctl = '0;
	wire logic [4:0]                   rxdet, tdone;
	wire logic [2:0]                   tw;
	logic [39:0]                       orx, otx;
	logic [3:0]                        linv, lpd;
	logic [2:0]                        omw, onw;
	link_ctl_pkg::ltssm_state_t [4:0]  st;
	logic [4:0]                        spd, lup, flush, ur, cfg, fca, spls, blk;
	link_ctl_pkg::slot_power_t         cap;
	logic [4:0]                        sf = 5'h00, sa = 5'h00, ss = 5'h00;
	int                                miscompares = 0;
	int                                checked = 0;
	int                                seed = 32'h5C800C23;
	int                                exp_inv[$];

	always #2.5 i_core_clk = ~i_core_clk;

	// One-cycle pulses are collected on the falling edge, clear of the launching edge.
	always @(negedge i_core_clk) begin
		sf = sf | flush;
		sa = sa | fca;
		ss = ss | spls;
	end

	link_partner_model u_partner (.i_core_clk(i_core_clk), .i_go(go), .i_width(pw), .i_delay(dly),
		.o_rx_detect(rxdet), .o_train_done(tdone), .o_trained_width(tw));

	switch_link_operation_control u_dut (.i_core_clk(i_core_clk), .i_srst(srst), .i_fundamental_reset_pin_n(pin_n),
		.i_register_unlock_bit(unlock), .i_max_width_wr(mw_wr), .i_max_width_field(mw), .i_port_ctl(ctl),
		.i_train_done(tdone), .i_rx_detect(rxdet), .i_trained_width(tw), .i_lanes_reversed(rev),
		.i_ts_valid(tsv), .i_ts_index(tsidx), .i_ts_inv(tsinv), .i_rx_data(rxd), .i_tx_data(txd),
		.i_spl_msg_valid(spl_v), .i_spl_payload(pay), .o_rx_data(orx), .o_tx_data(otx), .o_lane_inverted(linv),
		.o_max_width_field(omw), .o_negotiated_width_field(onw), .o_up_lane_pd(lpd), .o_port_serdes_pd(spd),
		.o_ltssm_state(st), .o_link_up(lup), .o_flush_queue(flush), .o_ur_to_port(ur), .o_cfg_accept(cfg),
		.o_fc_advertise(fca), .o_spl_send(spls), .o_tlp_dllp_block(blk), .o_captured_power(cap));

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge i_core_clk);
			#1;
		end
	endtask

	task automatic wait_state(input int p, input link_ctl_pkg::ltssm_state_t s);
		for (int k = 0; k < 60 && st[p] !== s; k++) tick(1);
		`CHK("ltssm_state", s, st[p])
	endtask

	// Raises control bits of one port for exactly one edge.
	task automatic kick(input int p, input logic [6:0] c);
		ctl[p] = link_ctl_pkg::port_ctl_t'(ctl[p] | c);
		tick(1);
		ctl[p] = link_ctl_pkg::port_ctl_t'(ctl[p] & ~c);
	endtask

	task automatic final_report();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		miscompares++;
		final_report();
	end

	initial begin
		logic [4:0] idx;
		tick(20);
		srst = 1'b0;
		tick(1);
		`CHK("max_width", link_ctl_pkg::MAX_WIDTH_RST, omw)
		`CHK("neg_width", link_ctl_pkg::NEG_WIDTH_RST, onw)
		`CHK("cfg_accept", 5'h1F, cfg)
		`CHK("link_up", 5'h00, lup)
		`CHK("captured", {link_ctl_pkg::PWR_SCALE_RST, link_ctl_pkg::PWR_VALUE_RST}, cap)
		$display("test reset done");
		dly = 8'h14;
		go[0] = 1'b1;
		wait_state(0, link_ctl_pkg::LS_CONFIG);
		rxd = {8'($random(seed)), 32'($random(seed))};
		txd = {8'($random(seed)), 32'($random(seed))};
		for (int l = 0; l < 4; l++) begin
			idx = 5'($unsigned($random(seed)) % 20);
			tsidx[l*5 +: 5] = idx;
			exp_inv.push_back(int'(idx >= 5'h06 && idx <= 5'h10));
		end
		tsv = 4'hF;
		tsinv = 4'hF;
		tick(1);
		tsv = 4'h0;
		tick(2);
		for (int l = 0; l < 4; l++) begin
			`CHK("lane_inverted", exp_inv[l][0], linv[l])
			`CHK("rx_data", rxd[l*10 +: 10] ^ {10{exp_inv[l][0]}}, orx[l*10 +: 10])
		end
		`CHK("tx_data", txd, otx)
		sa = 5'h00;
		ss = 5'h00;
		go[4:1] = 4'hF;
		wait_state(0, link_ctl_pkg::LS_L0);
		for (int p = 1; p < 5; p++) wait_state(p, link_ctl_pkg::LS_L0);
		tick(3);
		for (int l = 0; l < 4; l++) `CHK("lane_inverted_held", exp_inv[l][0], linv[l])
		`CHK("fc_advertise", 5'h1F, sa)
		`CHK("spl_send", 5'h1E, ss)
		`CHK("link_up", 5'h1F, lup)
		`CHK("ur", 5'h00, ur)
		`CHK("neg_width", link_ctl_pkg::WIDTH_X4, onw)
		`CHK("lane_pd", 4'h0, lpd)
		$display("test bring_up done");
		mw = link_ctl_pkg::WIDTH_X2;
		mw_wr = 1'b1;
		tick(1);
		mw_wr = 1'b0;
		`CHK("max_width_locked", link_ctl_pkg::WIDTH_X4, omw)
		tick(1);
		unlock = 1'b1;
		mw_wr = 1'b1;
		tick(1);
		mw_wr = 1'b0;
		tick(1);
		`CHK("max_width", link_ctl_pkg::WIDTH_X2, omw)
		`CHK("neg_width_live", link_ctl_pkg::WIDTH_X4, onw)
		mw = 3'h3;
		mw_wr = 1'b1;
		tick(1);
		mw_wr = 1'b0;
		tick(1);
		`CHK("max_width_illegal", link_ctl_pkg::WIDTH_X2, omw)
		rev = 1'b1;
		kick(0, 7'h20);
		`CHK("ltssm_full", link_ctl_pkg::LS_DETECT, st[0])
		wait_state(0, link_ctl_pkg::LS_L0);
		`CHK("neg_width", link_ctl_pkg::WIDTH_X2, onw)
		`CHK("lane_pd", 4'hC, lpd)
		`CHK("tx_data_rev", {txd[39:20], txd[9:0], txd[19:10]}, otx)
		`CHK("rx_data_rev", {rxd[9:0] ^ {10{exp_inv[0][0]}}, rxd[19:10] ^ {10{exp_inv[1][0]}}}, orx[19:0])
		$display("test width done");
		unlock = 1'b0;
		kick(0, 7'h40);
		`CHK("ltssm_locked", link_ctl_pkg::LS_L0, st[0])
		unlock = 1'b1;
		tick(1);
		kick(0, 7'h40);
		`CHK("ltssm_retrain", link_ctl_pkg::LS_RECOVERY, st[0])
		unlock = 1'b0;
		kick(1, 7'h40);
		`CHK("ltssm_retrain", link_ctl_pkg::LS_RECOVERY, st[1])
		wait_state(0, link_ctl_pkg::LS_L0);
		wait_state(1, link_ctl_pkg::LS_L0);
		$display("test retrain done");
		ss = 5'h00;
		kick(2, 7'h01);
		tick(2);
		`CHK("spl_send_write", 5'h04, ss)
		pay = 16'($random(seed));
		spl_v = 1'b1;
		tick(1);
		spl_v = 1'b0;
		tick(1);
		`CHK("captured", {pay[7:0], pay[9:8]}, cap)
		$display("test slot_power done");
		sf = 5'h00;
		ctl[3] = link_ctl_pkg::port_ctl_t'(ctl[3] | 7'h10);
		tick(1);
		`CHK("ltssm_disabled", link_ctl_pkg::LS_DISABLED, st[3])
		`CHK("serdes_pd", 1'b1, spd[3])
		`CHK("link_up_off", 1'b0, lup[3])
		`CHK("ur_down", 1'b1, ur[3])
		tick(2);
		`CHK("flush", 1'b1, sf[3])
		ctl[2] = link_ctl_pkg::port_ctl_t'(ctl[2] | 7'h08);
		wait_state(2, link_ctl_pkg::LS_L1);
		$display("test down_l1 done");
		// The partner acknowledges the power-off request by holding this level.
		ctl[4] = link_ctl_pkg::port_ctl_t'(ctl[4] | 7'h02);
		tick(1);
		`CHK("ltssm_l23", link_ctl_pkg::LS_L23_RDY, st[4])
		`CHK("tlp_block", 1'b1, blk[4])
		tick(1);
		`CHK("ltssm_l2", link_ctl_pkg::LS_L2, st[4])
		kick(4, 7'h20);
		tick(2);
		`CHK("ltssm_l2_held", link_ctl_pkg::LS_L2, st[4])
		ctl[4] = '0;
		go[4] = 1'b0;
		pin_n = 1'b0;
		tick(6);
		`CHK("ltssm_pin", link_ctl_pkg::LS_DETECT, st[4])
		pin_n = 1'b1;
		$display("test l2 done");
		final_report();
	end
endmodule

`default_nettype wire
